// [core/pcl_loader.sv]
// Purpose: control block that programs serial channel addresses and
//          interrupt numbers from a byte image held on the board
// Assumes: host bus pins are asynchronous and are synchronised here
// Notes:   image storage is flip-flops and keeps its content over srst
`include "pcl_regs.svh"

module pcl_loader
	import pcl_pkg::*;
#(
	parameter int NUM_CHANNELS = 8,
	parameter int WRITE_CYCLES = `PCL_EE_WRITE_MS * `PCL_CLK_KHZ
)(
	input  wire logic                    sys_clk,
	input  wire logic                    srst,
	input  wire logic [9:0]              host_addr,
	input  wire logic                    host_aen,
	input  wire logic                    host_iow_n,
	input  wire logic                    host_ior_n,
	input  wire logic [7:0]              host_data_in,
	output logic      [7:0]              host_data_out,
	output logic                         host_data_oe,
	input  wire logic [5:0]              base_jumper_installed,
	input  wire logic                    port_disable_jumper,
	output logic      [NUM_CHANNELS-1:0] chan_select,
	output logic      [NUM_CHANNELS-1:0][7:0] chan_irq_number,
	output logic                         irq_enable,
	output logic                         image_busy
);

	if (NUM_CHANNELS != 2 && NUM_CHANNELS != 4 && NUM_CHANNELS != 8)
	begin : g_bad_channels
		$error("pcl_loader: NUM_CHANNELS must be 2, 4 or 8");
	end
	if (WRITE_CYCLES < 1)
	begin : g_bad_write_time
		$error("pcl_loader: WRITE_CYCLES must be at least 1");
	end

	localparam int CW = $clog2(WRITE_CYCLES + 1);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: every pin passes two flip-flops first

	pcl_bus_t   pin_bus;
	pcl_bus_t   sync1_reg,  sync2_reg;
	logic [6:0] jmp1_reg,   jmp2_reg;
	logic       iow_prev_reg, ior_prev_reg;

	always_comb
	begin
		pin_bus.addr = host_addr;
		pin_bus.aen  = host_aen;
		pin_bus.iow  = ~host_iow_n;
		pin_bus.ior  = ~host_ior_n;
		pin_bus.data = host_data_in;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			sync1_reg    <= '0;
			sync2_reg    <= '0;
			jmp1_reg     <= `PCL_RST_JUMPERS;
			jmp2_reg     <= `PCL_RST_JUMPERS;
			iow_prev_reg <= 1'b0;
			ior_prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg    <= pin_bus;
			sync2_reg    <= sync1_reg;
			jmp1_reg     <= {port_disable_jumper, base_jumper_installed};
			jmp2_reg     <= jmp1_reg;
			iow_prev_reg <= sync2_reg.iow;
			ior_prev_reg <= sync2_reg.ior;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode

	logic [5:0] base_value;
	logic       base_hit;
	logic [3:0] offset;
	logic       wr_pulse;
	logic       rd_active;
	logic       ports_off;

	logic [7:0][6:0] chan_addr_reg,  chan_addr_next;
	logic [4:0][7:0] irq_num_reg,    irq_num_next;

	// channel hit on host lines nine to three
	function automatic logic chan_hit(input logic [6:0] stored,
		input logic [9:0] addr, input logic aen);
		chan_hit = !aen && addr[`PCL_CHAN_MSB:`PCL_CHAN_LSB] == stored;
	endfunction : chan_hit

	always_comb
	begin
		base_value = ~jmp2_reg[5:0];
		base_hit   = !sync2_reg.aen &&
			sync2_reg.addr[`PCL_BASE_MSB:`PCL_BASE_LSB] == base_value;
		offset     = sync2_reg.addr[3:0];
		wr_pulse   = sync2_reg.iow && !iow_prev_reg;
		rd_active  = sync2_reg.ior;
		ports_off  = jmp2_reg[6];
	end

	logic [NUM_CHANNELS-1:0] hit_now;
	logic                    uart_write;

	always_comb
	begin
		for (int i = 0; i < NUM_CHANNELS; i++)
			hit_now[i] = !ports_off && !base_hit &&
				chan_hit(chan_addr_reg[i], sync2_reg.addr,
				sync2_reg.aen);
		uart_write = wr_pulse && |hit_now;
	end

	////////////////////////////////////////////////////////////////////////
	// control state, image storage and channel registers

	pcl_state_t      state_reg,     state_next;
	logic [CW-1:0]   count_reg,     count_next;
	logic [3:0]      location_reg,  location_next;
	logic [7:0]      wdata_reg,     wdata_next;
	logic            load_reg,      load_next;
	logic            irqen_reg,     irqen_next;
	logic [15:0][7:0] image_reg,    image_next;
	logic [7:0]      rdata_reg,     rdata_next;
	logic [NUM_CHANNELS-1:0] sel_reg, sel_next;
	logic            idle_wr;

	always_comb
	begin
		state_next     = state_reg;
		count_next     = count_reg;
		location_next  = location_reg;
		wdata_next     = wdata_reg;
		load_next      = 1'b0;
		irqen_next     = irqen_reg;
		image_next     = image_reg;
		chan_addr_next = chan_addr_reg;
		irq_num_next   = irq_num_reg;
		rdata_next     = image_reg[location_reg];
		sel_next       = hit_now;
		// control block writes during an image write are ignored
		idle_wr        = wr_pulse && base_hit && state_reg == PCL_IDLE;

		if (uart_write)
			irqen_next = 1'b1;
		if (idle_wr)
		begin
			unique case (offset)
				`PCL_OFF_IRQ_ENABLE:  irqen_next = 1'b1;
				`PCL_OFF_EE_LOCATION: location_next = sync2_reg.data[3:0];
				`PCL_OFF_EE_DATA:
				begin
					wdata_next = sync2_reg.data;
					state_next = PCL_BUSY;
					count_next = CW'(WRITE_CYCLES - 1);
				end
				`PCL_OFF_RELOAD:      load_next = 1'b1;
				default:              ;
			endcase
		end

		unique case (state_reg)
			PCL_IDLE: ;
			PCL_BUSY:
			begin
				// byte commits at the end of the write time
				if (count_reg == '0)
				begin
					image_next[location_reg] = wdata_reg;
					state_next = PCL_IDLE;
				end
				else
					count_next = count_reg - 1'b1;
			end
		endcase

		if (load_reg)
		begin
			for (int i = 0; i < NUM_CHANNELS; i++)
			begin
				chan_addr_next[i] =
					image_reg[`PCL_EE_ADDR_FIRST + 4'(i)][6:0];
				irq_num_next[i < `PCL_IRQ_INDIVIDUAL ? i :
					`PCL_IRQ_INDIVIDUAL] = i < `PCL_IRQ_INDIVIDUAL ?
					image_reg[`PCL_EE_IRQ_FIRST + 4'(i)] :
					image_reg[`PCL_EE_IRQ_SHARED];
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_reg     <= PCL_IDLE;
			count_reg     <= '0;
			location_reg  <= `PCL_RST_LOCATION;
			wdata_reg     <= `PCL_RST_BYTE;
			load_reg      <= 1'b1;
			irqen_reg     <= 1'b0;
			chan_addr_reg <= '0;
			irq_num_reg   <= '0;
			rdata_reg     <= `PCL_RST_BYTE;
			sel_reg       <= '0;
		end
		else
		begin
			state_reg     <= state_next;
			count_reg     <= count_next;
			location_reg  <= location_next;
			wdata_reg     <= wdata_next;
			load_reg      <= load_next;
			irqen_reg     <= irqen_next;
			chan_addr_reg <= chan_addr_next;
			irq_num_reg   <= irq_num_next;
			rdata_reg     <= rdata_next;
			sel_reg       <= sel_next;
		end
	end

	// image is nonvolatile content, so srst leaves it alone
	always_ff @(posedge sys_clk)
	begin
		image_reg <= image_next;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	always_comb
	begin
		host_data_out = rdata_reg;
		// only the data port is driven on reads
		host_data_oe  = rd_active && base_hit &&
			offset == `PCL_OFF_EE_DATA;
		chan_select   = sel_reg;
		for (int i = 0; i < NUM_CHANNELS; i++)
			chan_irq_number[i] = irq_num_reg[i < `PCL_IRQ_INDIVIDUAL ? i :
				`PCL_IRQ_INDIVIDUAL];
		irq_enable    = irqen_reg;
		image_busy    = state_reg == PCL_BUSY;
	end

endmodule : pcl_loader

// [core/pcl_pkg.sv]
// Purpose: types of the port configuration loader
// Assumes: nothing beyond the register header
// Notes:   host bus sample travels as one packed struct
package pcl_pkg;

	// one sample of the host i/o bus, strobes made active high
	typedef struct packed {
		logic [9:0] addr;
		logic       aen;
		logic       iow;
		logic       ior;
		logic [7:0] data;
	} pcl_bus_t;

	typedef enum logic [1:0] {
		PCL_IDLE = 2'b01,
		PCL_BUSY = 2'b10
	} pcl_state_t;

endpackage : pcl_pkg

// [core/pcl_regs.svh]
// Purpose: offsets, field positions, reset values and timing counts of the
//          port configuration loader
// Assumes: control block decoded on host address lines 9..4
// Notes:   definitions only
`ifndef PCL_REGS_SVH
`define PCL_REGS_SVH

// control block offsets
`define PCL_OFF_IRQ_ENABLE    4'h0
`define PCL_OFF_EE_LOCATION   4'h1
`define PCL_OFF_EE_DATA       4'h2
`define PCL_OFF_RELOAD        4'h3

// host address fields
`define PCL_BASE_MSB          9
`define PCL_BASE_LSB          4
`define PCL_CHAN_MSB          9
`define PCL_CHAN_LSB          3

// stored image layout
`define PCL_EE_ADDR_FIRST     4'h1
`define PCL_EE_IRQ_FIRST      4'h9
`define PCL_EE_IRQ_SHARED     4'hd
`define PCL_IRQ_INDIVIDUAL    4

// reset values
`define PCL_RST_BYTE          8'h00
`define PCL_RST_LOCATION      4'h0
// disable bit set: channels stay silent until the jumpers are synchronised
`define PCL_RST_JUMPERS       7'h40

// timing
`define PCL_CLK_KHZ           25000
`define PCL_EE_WRITE_MS       2

`endif

// [verification/pcl_host.sv]
// Purpose: host processor on the i/o bus
// Assumes: pins change just after a rising edge
// Notes:   released data shows the inverse byte
module pcl_host
	import pcl_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       image_busy,
	input  wire logic [7:0] host_data_out,
	input  wire logic       host_data_oe,
	output logic      [9:0] host_addr,
	output logic            host_aen,
	output logic            host_iow_n,
	output logic            host_ior_n,
	output logic      [7:0] host_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		host_addr = 10'h000;
		host_aen = 1'b0;
		host_iow_n = 1'b1;
		host_ior_n = 1'b1;
		host_data_in = 8'h00;
	end
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		int n = 0;
		host_addr <= a;
		host_aen <= 1'b0;
		host_data_in <= d;
		@(posedge sys_clk);
		host_iow_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		host_iow_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		host_data_in <= ~d;
		// stay off the bus while the image byte is stored
		do @(posedge sys_clk); while (image_busy && ++n < 40);
	endtask : wr
	task automatic rd(input logic [9:0] a, output logic [7:0] d,
		output logic o);
		host_addr <= a;
		@(posedge sys_clk);
		host_ior_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		d = host_data_out;
		o = host_data_oe;
		host_ior_n <= 1'b1;
		@(posedge sys_clk);
	endtask : rd
	task automatic look(input logic [9:0] a, input logic e);
		host_addr <= a;
		host_aen <= e;
		repeat (5) @(posedge sys_clk);
	endtask : look
endmodule : pcl_host

// [verification/pcl_loader_tb_top.sv]
// Purpose: self-checking bench of the loader
// Assumes: control block at 200, channels at 300
// Notes:   short write time keeps the run small
module pcl_loader_tb_top
	import pcl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, srst, host_aen, host_iow_n, host_ior_n, host_data_oe;
	logic port_disable_jumper, irq_enable, image_busy, o;
	logic [9:0] host_addr;
	logic [7:0] host_data_in, host_data_out, chan_select, d;
	logic [7:0][7:0] chan_irq_number;
	logic [5:0] base_jumper_installed;
	int errors, n_checks;
	pcl_loader #(.NUM_CHANNELS(8), .WRITE_CYCLES(8)) i_dut (.sys_clk,
		.srst, .host_addr, .host_aen, .host_iow_n, .host_ior_n,
		.host_data_in, .host_data_out, .host_data_oe,
		.base_jumper_installed, .port_disable_jumper, .chan_select,
		.chan_irq_number, .irq_enable, .image_busy);
	pcl_host i_host (.sys_clk, .image_busy, .host_data_out, .host_data_oe,
		.host_addr, .host_aen, .host_iow_n, .host_ior_n, .host_data_in);
	function automatic logic [7:0] img(input int i);
		return (i < 9) ? 8'h5f + 8'(i) : 8'(i) - 8'h04;
	endfunction : img
	task automatic chk(input string n, input logic [7:0] s, e);
		n_checks++;
		if (s !== e)
		begin
			$display("ERROR %s exp %h got %h", n, e, s);
			errors++;
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial
	begin
		repeat (6000) @(posedge sys_clk);
		errors++;
		wrap_up();
	end
	initial
	begin
		srst = 1'b1;
		base_jumper_installed = 6'h1f;
		port_disable_jumper = 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("irq_en", irq_enable, 8'h00);
		for (int i = 1; i < 14; i++)
		begin
			i_host.wr(10'h201, 8'(i));
			i_host.wr(10'h202, img(i));
		end
		i_host.wr(10'h201, 8'h0c);
		i_host.rd(10'h202, d, o);
		chk("ee_data", d, img(12));
		chk("oe_data", o, 8'h01);
		i_host.rd(10'h201, d, o);
		chk("oe_loc", o, 8'h00);
		i_host.rd(10'h203, d, o);
		chk("oe_reload", o, 8'h00);
		i_host.wr(10'h201, 8'h0e);
		fork
			i_host.wr(10'h202, 8'h33);
			begin
				repeat (6) @(posedge sys_clk);
				chk("busy", image_busy, 8'h01);
			end
		join
		chk("busy", image_busy, 8'h00);
		i_host.rd(10'h202, d, o);
		chk("ee_commit", d, 8'h33);
		$display("test image done");
		i_host.wr(10'h203, 8'h5a);
		for (int c = 0; c < 8; c++)
		begin
			chk("irq_num", chan_irq_number[c], img(c < 4 ? 9 + c : 13));
			i_host.look(10'h300 + 10'(9 * c), 1'b0);
			chk("sel_off", chan_select, 8'h00);
		end
		port_disable_jumper <= 1'b0;
		for (int c = 0; c < 8; c++)
		begin
			i_host.look(10'h300 + 10'(9 * c), 1'b0);
			chk("sel_on", chan_select, 8'h01 << c);
		end
		i_host.look(10'h308, 1'b1);
		chk("sel_aen", chan_select, 8'h00);
		chk("irq_en", irq_enable, 8'h00);
		i_host.wr(10'h308, 8'h41);
		chk("irq_en", irq_enable, 8'h01);
		$display("test decode done");
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("irq_num", chan_irq_number[3], img(12));
		chk("irq_en", irq_enable, 8'h00);
		i_host.wr(10'h200, 8'h00);
		chk("irq_en", irq_enable, 8'h01);
		$display("test restart done");
		wrap_up();
	end
endmodule : pcl_loader_tb_top

// [verification/pcl_props.sv]
// Purpose: port properties of the loader
// Assumes: one clock, synchronous reset
// Notes:   pins pass two sync flops
module pcl_props
	import pcl_pkg::*;
#(
	parameter int NUM_CHANNELS = 8,
	parameter int WRITE_CYCLES = 8
)(
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic [9:0]  host_addr,
	input wire logic        host_aen,
	input wire logic        host_iow_n,
	input wire logic        host_ior_n,
	input wire logic        host_data_oe,
	input wire logic [5:0]  base_jumper_installed,
	input wire logic        port_disable_jumper,
	input wire logic [NUM_CHANNELS-1:0] chan_select,
	input wire logic [NUM_CHANNELS-1:0][7:0] chan_irq_number,
	input wire logic        irq_enable,
	input wire logic        image_busy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic [15:0] bc_reg;
	logic [15:0] bc_next;
	logic [9:0]  data_at;
	assign data_at = {~base_jumper_installed, 4'h2};
	always_comb bc_next = (image_busy && !srst) ? bc_reg + 16'h1 : 16'h0;
	always_ff @(posedge sys_clk) bc_reg <= bc_next;
	a_busy_len: assert property ($fell(image_busy) |->
		bc_reg == WRITE_CYCLES) else $error("busy length wrong");
	a_busy_cause: assert property ($rose(image_busy) |->
		!$past(host_iow_n, 3) && $past(host_addr, 3) == data_at)
		else $error("busy without data write");
	a_oe_cause: assert property (host_data_oe |->
		!$past(host_ior_n, 2) && $past(host_addr, 2) == data_at)
		else $error("read drive at wrong place");
	a_sel_quiet: assert property (port_disable_jumper [*4] |->
		chan_select == '0) else $error("channel hit while disabled");
	a_aen_quiet: assert property (host_aen [*4] |->
		chan_select == '0) else $error("channel hit in dma cycle");
	a_irq_cause: assert property ($rose(irq_enable) |->
		!$past(host_iow_n, 3)) else $error("irq enable without write");
	a_irq_hold: assert property (irq_enable |=> irq_enable)
		else $error("irq enable dropped");
	a_irq_shared: assert property (chan_irq_number[5] ===
		chan_irq_number[4] && chan_irq_number[6] === chan_irq_number[4]
		&& chan_irq_number[7] === chan_irq_number[4])
		else $error("shared irq differs");
endmodule : pcl_props

bind pcl_loader pcl_props #(.NUM_CHANNELS(NUM_CHANNELS),
	.WRITE_CYCLES(WRITE_CYCLES)) i_props (.sys_clk, .srst, .host_addr,
	.host_aen, .host_iow_n, .host_ior_n, .host_data_oe,
	.base_jumper_installed, .port_disable_jumper, .chan_select,
	.chan_irq_number, .irq_enable, .image_busy);
